// ---- sdmc_i2c_master.sv ----
// Behavioural I2C bus master that talks to the sensor's serial pins
module sdmc_i2c_master (
	// Bus pins, open drain on data
	output logic      scl,
	output logic      sda_low,
	input  wire logic sda
);
	timeunit 1ns;
	timeprecision 1ps;
	// Quarter bit; the link runs fast here to keep the run short
	localparam int Q = 12;

	// Clock stands high between frames
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	task automatic bit_out(input logic b);
		#Q sda_low = ~b;
		#Q scl = 1'b1;
		#(2*Q) scl = 1'b0;
	endtask : bit_out

	task automatic bit_in(output logic v);
		#Q sda_low = 1'b0;
		#Q scl = 1'b1;
		#Q v = sda;
		#Q scl = 1'b0;
	endtask : bit_in

	task automatic start_cond();
		#Q sda_low = 1'b1;
		#Q scl = 1'b0;
	endtask : start_cond

	task automatic stop_cond();
		#Q sda_low = 1'b1;
		#Q scl = 1'b1;
		#Q sda_low = 1'b0;
		#Q;
	endtask : stop_cond

	task automatic send_byte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_out(d[i]);
		end
		bit_in(s);
		ack = ~s;
	endtask : send_byte

	task automatic recv_byte(input logic last, output logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			bit_in(b[i]);
		end
		bit_out(last);
	endtask : recv_byte

	// Address, optional command byte; codes shared via the package
	task automatic write(input logic [6:0] a, input logic has_d, input logic [7:0] d, output logic ack);
		logic k;
		k = 1'b1;
		start_cond();
		send_byte({a, 1'b0}, ack);
		if (ack && has_d) begin
			send_byte(d, k);
		end
		ack = ack & k;
		stop_cond();
	endtask : write

	// Four-byte fetch, NACK on the last
	task automatic read(input logic [6:0] a, output logic ack, output logic [31:0] d);
		logic [7:0] b;
		d = 32'h0000_0000;
		start_cond();
		send_byte({a, 1'b1}, ack);
		for (int i = 0; i < 4; i++) begin
			if (ack) begin
				recv_byte(i == 3, b);
				d = {d[23:0], b};
			end
		end
		stop_cond();
	endtask : read
endmodule : sdmc_i2c_master

// ---- sdmc_pkg.sv ----
// Constants, types and encodings for the sensor start-up and mode control block
package sdmc_pkg;
	// Clock rate
	localparam int unsigned CLK_MHZ        = 250;
	// Command window lengths
	localparam int unsigned WIN_SLOW_MS    = 10;
	localparam int unsigned WIN_FAST_MS    = 3;
	localparam int unsigned WIN_SLOW_CYC   = WIN_SLOW_MS * 1000 * CLK_MHZ;
	localparam int unsigned WIN_FAST_CYC   = WIN_FAST_MS * 1000 * CLK_MHZ;
	// Measurement cycle phases
	localparam int unsigned TEMP_US        = 500;
	localparam int unsigned HUM_US         = 500;
	localparam int unsigned CALC_US        = 250;
	localparam int unsigned TEMP_CYC       = TEMP_US * CLK_MHZ;
	localparam int unsigned HUM_CYC        = HUM_US * CLK_MHZ;
	localparam int unsigned CALC_CYC       = CALC_US * CLK_MHZ;
	// Start-up limit, power-on to first ready
	localparam int unsigned STA_MAX_MS     = 55;
	localparam int unsigned STA_MAX_CYC    = STA_MAX_MS * 1000 * CLK_MHZ;
	localparam int unsigned CNT_W          = 22;
	localparam int unsigned BOOT_W         = 24;
	// Command codes, shared with the bus master
	localparam logic [7:0]  ENTER_CM_CODE  = 8'hA0;
	localparam logic [7:0]  ENTER_NOM_CODE = 8'h80;
	// Status bits of the first fetched byte
	localparam logic [1:0]  ST_VALID       = 2'h0;
	localparam logic [1:0]  ST_STALE       = 2'h1;
	localparam logic [1:0]  ST_CMD         = 2'h2;
	// Reset values
	localparam logic [6:0]  ADDR_RST       = 7'h00;
	localparam logic [13:0] MEAS_RST       = 14'h0000;

	typedef struct packed {
		logic [13:0] hum;
		logic [13:0] temp;
	} sdmc_meas_s;

	typedef enum logic [5:0] {
		M_WIN  = 6'h01,
		M_CMD  = 6'h02,
		M_TEMP = 6'h04,
		M_HUM  = 6'h08,
		M_CALC = 6'h10,
		M_OUT  = 6'h20
	} sdmc_main_e;

	typedef enum logic [6:0] {
		I_IDLE = 7'h01,
		I_ADDR = 7'h02,
		I_AACK = 7'h04,
		I_WDAT = 7'h08,
		I_DACK = 7'h10,
		I_RDAT = 7'h20,
		I_RACK = 7'h40
	} sdmc_i2c_e;
endpackage : sdmc_pkg

// ---- sdmc_tb.sv ----
// Self-checking bench for start-up, mode entry and fetch of the sensor block
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	// Short counts so the run stays brief
	localparam int W_SLOW = 400;
	localparam int W_FAST = 120;
	localparam int CYC = 50;
	localparam logic [31:0] MSK = 32'hFFFF_FFFC;

	logic                 ref_clk = 1'b0;
	logic                 rst_n = 1'b0;
	logic                 quick_boot = 1'b0;
	logic                 output_pdm = 1'b0;
	logic [6:0]           slave_address_field = 7'h00;
	sdmc_pkg::sdmc_meas_s meas_in = 28'h0000000;
	logic                 scl;
	logic                 sda_low;
	logic                 sda_out;
	logic                 sda_oe;
	logic                 ready;
	logic                 command_mode;
	logic                 i2c_active;
	logic                 meas_busy;
	int                   num_errors = 0;
	int                   comparisons = 0;
	// Pull-up wire; either party may pull it low
	wire                  sda = ~(sda_low | (sda_oe & ~sda_out));

	initial begin
		forever #2 ref_clk = ~ref_clk;
	end

	sdmc_top #(.WIN_SLOW_CYC(W_SLOW), .WIN_FAST_CYC(W_FAST), .TEMP_CYC(20), .HUM_CYC(20), .CALC_CYC(10)) DUT (
		.REF_CLK(ref_clk), .RST_N(rst_n), .SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
		.QUICK_BOOT(quick_boot), .OUTPUT_PDM(output_pdm), .SLAVE_ADDRESS_FIELD(slave_address_field),
		.MEAS_IN(meas_in), .READY(ready), .COMMAND_MODE(command_mode), .I2C_ACTIVE(i2c_active),
		.MEAS_BUSY(meas_busy)
	);

	sdmc_i2c_master mst (.scl(scl), .sda_low(sda_low), .sda(sda));

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic boot(input logic qb, input logic pdm, input logic [6:0] a);
		@(negedge ref_clk);
		rst_n = 1'b0;
		quick_boot = qb;
		output_pdm = pdm;
		slave_address_field = a;
		repeat (2) @(negedge ref_clk);
		rst_n = 1'b1;
	endtask : boot

	// Cycles until busy reaches the level, bounded
	task automatic wait_busy(input logic lvl, output int n);
		n = 0;
		while (meas_busy !== lvl && n < 2000) begin
			@(negedge ref_clk);
			n++;
		end
	endtask : wait_busy

	function automatic logic [31:0] img(input logic [1:0] st, input sdmc_pkg::sdmc_meas_s m);
		return {st, m.hum, m.temp, 2'b00};
	endfunction : img

	task automatic test_slow();
		int n;
		logic ack;
		logic [31:0] d;
		meas_in = {14'h2A5C, 14'h1234};
		boot(1'b0, 1'b0, 7'h7F);
		chk(i2c_active, 1'b1);
		chk(command_mode, 1'b0);
		wait_busy(1'b1, n);
		chk(n >= W_SLOW - 1 && n <= W_SLOW + 4, 1'b1);
		chk(ready, 1'b0);
		wait_busy(1'b0, n);
		chk(n >= CYC - 1 && n <= CYC + 2, 1'b1);
		@(negedge ref_clk);
		chk(ready, 1'b1);
		meas_in = {14'h15A3, 14'h3C0F};
		mst.write(7'h7F, 1'b0, 8'h00, ack);
		chk(ack, 1'b1);
		wait_busy(1'b0, n);
		@(negedge ref_clk);
		chk(ready, 1'b1);
		mst.read(7'h7F, ack, d);
		chk(d & MSK, img(sdmc_pkg::ST_VALID, meas_in));
		repeat (4) @(negedge ref_clk);
		chk(ready, 1'b0);
		mst.read(7'h7F, ack, d);
		chk(d[31:30], sdmc_pkg::ST_STALE);
		$display("test slow start-up done");
	endtask : test_slow

	task automatic test_quick();
		int n;
		logic ack;
		logic [31:0] d;
		boot(1'b1, 1'b0, 7'h00);
		wait_busy(1'b1, n);
		chk(n >= W_FAST - 1 && n <= W_FAST + 4, 1'b1);
		wait_busy(1'b0, n);
		mst.read(7'h01, ack, d);
		chk(ack, 1'b0);
		mst.read(7'h00, ack, d);
		chk(ack, 1'b1);
		chk(d & MSK, img(sdmc_pkg::ST_VALID, meas_in));
		$display("test quick start-up done");
	endtask : test_quick

	task automatic test_cmd();
		int n;
		logic ack;
		logic [31:0] d;
		boot(1'b0, 1'b0, 7'h55);
		mst.write(7'h55, 1'b1, sdmc_pkg::ENTER_CM_CODE, ack);
		chk(ack, 1'b1);
		chk(command_mode, 1'b1);
		repeat (W_SLOW) @(negedge ref_clk);
		chk({command_mode, meas_busy, ready}, 3'h4);
		mst.read(7'h55, ack, d);
		chk(d[31:30], sdmc_pkg::ST_CMD);
		mst.write(7'h55, 1'b1, sdmc_pkg::ENTER_NOM_CODE, ack);
		chk({ack, command_mode, meas_busy}, 3'h5);
		wait_busy(1'b0, n);
		@(negedge ref_clk);
		chk(ready, 1'b1);
		$display("test command mode done");
	endtask : test_cmd

	task automatic test_pdm();
		int n;
		logic ack;
		logic [31:0] d;
		boot(1'b0, 1'b1, 7'h33);
		mst.write(7'h33, 1'b0, 8'h00, ack);
		chk(ack, 1'b1);
		wait_busy(1'b1, n);
		wait_busy(1'b0, n);
		mst.read(7'h33, ack, d);
		chk({ack, i2c_active}, 2'h0);
		$display("test programmed output done");
	endtask : test_pdm

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : end_sim

	initial begin
		test_slow();
		test_quick();
		test_cmd();
		test_pdm();
		end_sim();
	end

	// Whole run needs well under this span
	initial begin
		#100us;
		num_errors++;
		$display("watchdog expired at %0t", $time);
		end_sim();
	end
endmodule : testbench

// ---- sdmc_top.sv ----
// Start-up window, mode entry, measurement cycle and I2C slave of the sensor
// Functional notes
// (RULE1) After power-on the device always acts as I2C slave, whatever output is programmed.
// (RULE2) After reset a command window opens: 10 ms, or 3 ms with quick boot.
// (RULE3) Enter-command-mode inside the window enters command mode and stays there.
// (RULE4) Window timeout switches to output mode and runs one measurement cycle.
// (RULE5) Enter-normal-operation in command mode switches to output mode, one measurement.
// (RULE6) Slave answers on 7-bit address from the slave address field.
// (RULE7) Master clocks the bus between 20 kHz and 400 kHz; the bench master uses a 48 ns bit, about 20.8 MHz.
// (RULE8) Power-on to first ready data lies between 4.25 ms and 55 ms.
// (RULE9) Cycle: temperature, then humidity, then correction; output updated at end.
// (RULE10) Ready rises on new data and holds until a readout request.
// (RULE11) Command codes are configurable constants shared by both parties.
module sdmc_top #(
	parameter int unsigned WIN_SLOW_CYC = sdmc_pkg::WIN_SLOW_CYC,
	parameter int unsigned WIN_FAST_CYC = sdmc_pkg::WIN_FAST_CYC,
	parameter int unsigned TEMP_CYC     = sdmc_pkg::TEMP_CYC,
	parameter int unsigned HUM_CYC      = sdmc_pkg::HUM_CYC,
	parameter int unsigned CALC_CYC     = sdmc_pkg::CALC_CYC
) (
	// Clock and reset
	input  wire logic                 REF_CLK,
	input  wire logic                 RST_N,
	// I2C pins
	input  wire logic                 SCL,
	input  wire logic                 SDA_IN,
	output logic                      SDA_OUT,
	output logic                      SDA_OE,
	// Configuration word
	input  wire logic                 QUICK_BOOT,
	input  wire logic                 OUTPUT_PDM,
	input  wire logic [6:0]           SLAVE_ADDRESS_FIELD,
	// Front-end conversion results
	input  wire sdmc_pkg::sdmc_meas_s MEAS_IN,
	// Status
	output logic                      READY,
	output logic                      COMMAND_MODE,
	output logic                      I2C_ACTIVE,
	output logic                      MEAS_BUSY
);
	logic                 cfg_loaded;
	logic                 quick;
	logic                 pdm;
	logic [6:0]           addr;
	logic                 scl_s1, scl_s2, scl_d;
	logic                 sda_s1, sda_s2, sda_d;
	sdmc_pkg::sdmc_i2c_e  i_st;
	sdmc_pkg::sdmc_main_e m_st;
	sdmc_pkg::sdmc_main_e next_m_st;
	logic [3:0]           bitc;
	logic [7:0]           shreg;
	logic [7:0]           tx;
	logic [1:0]           byte_idx;
	logic                 rw;
	logic                 acked;
	logic                 cmd_stb;
	logic [7:0]           cmd_byte;
	logic                 fetch;
	logic                 mreq;
	logic [sdmc_pkg::CNT_W-1:0] cnt;
	logic                 ready;
	logic                 stale;
	logic [13:0]          meas_t;
	logic [13:0]          meas_h;
	sdmc_pkg::sdmc_meas_s outreg;

	// Configuration word is caught once, just after reset release
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			cfg_loaded <= 1'b0;
			quick      <= 1'b0;
			pdm        <= 1'b0;
			addr       <= sdmc_pkg::ADDR_RST;
		end else if (!cfg_loaded) begin
			cfg_loaded <= 1'b1;
			quick      <= QUICK_BOOT;
			pdm        <= OUTPUT_PDM;
			addr       <= SLAVE_ADDRESS_FIELD;
		end
	end

	// Bus pins come from the master's domain
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			{scl_s1, scl_s2, scl_d} <= 3'h7;
			{sda_s1, sda_s2, sda_d} <= 3'h7;
		end else begin
			{scl_s1, scl_s2, scl_d} <= {SCL, scl_s1, scl_s2};
			{sda_s1, sda_s2, sda_d} <= {SDA_IN, sda_s1, sda_s2};
		end
	end

	wire scl_rise = scl_s2 & ~scl_d;
	wire scl_fall = ~scl_s2 & scl_d;
	wire bus_start = scl_s2 & scl_d & sda_d & ~sda_s2;
	wire bus_stop = scl_s2 & scl_d & ~sda_d & sda_s2;
	wire in_boot = (m_st == sdmc_pkg::M_WIN) | (m_st == sdmc_pkg::M_CMD);
	// PDM parts still answer I2C until the start-up sequence ends
	wire i2c_on = ~pdm | in_boot;                                  // [RULE1]
	wire addr_hit = i2c_on & (shreg[7:1] == addr);                 // [RULE6]
	wire [1:0] status = COMMAND_MODE ? sdmc_pkg::ST_CMD : (stale ? sdmc_pkg::ST_STALE : sdmc_pkg::ST_VALID);
	wire [7:0] tx_byte = (byte_idx == 2'h0) ? {status, outreg.hum[13:8]} :
	                     (byte_idx == 2'h1) ? outreg.hum[7:0] :
	                     (byte_idx == 2'h2) ? outreg.temp[13:6] : {outreg.temp[5:0], 2'h0};
	// A fetch always opens with the status byte, whatever an earlier short read left
	wire [7:0] tx_first = {status, outreg.hum[13:8]};

	// I2C slave; SDA is only ever pulled low, changed after SCL falls
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			i_st     <= sdmc_pkg::I_IDLE;
			bitc     <= 4'h0;
			shreg    <= 8'h00;
			tx       <= 8'h00;
			byte_idx <= 2'h0;
			rw       <= 1'b0;
			acked    <= 1'b0;
			SDA_OE   <= 1'b0;
			cmd_stb  <= 1'b0;
			cmd_byte <= 8'h00;
			fetch    <= 1'b0;
			mreq     <= 1'b0;
		end else begin
			cmd_stb <= 1'b0;
			fetch   <= 1'b0;
			mreq    <= 1'b0;
			if (bus_start) begin
				i_st   <= sdmc_pkg::I_ADDR;
				bitc   <= 4'h0;
				SDA_OE <= 1'b0;
			end else if (bus_stop) begin
				i_st   <= sdmc_pkg::I_IDLE;
				SDA_OE <= 1'b0;
			end else if (scl_rise) begin
				case (i_st)
					sdmc_pkg::I_ADDR, sdmc_pkg::I_WDAT: begin
						shreg <= {shreg[6:0], sda_s2};
						bitc  <= bitc + 4'h1;
					end
					sdmc_pkg::I_RDAT: bitc <= bitc + 4'h1;
					sdmc_pkg::I_RACK: acked <= ~sda_s2;
					default: ;
				endcase
			end else if (scl_fall) begin
				case (i_st)
					sdmc_pkg::I_ADDR: begin
						if (bitc == 4'h8 && addr_hit) begin   // [RULE6]
							i_st   <= sdmc_pkg::I_AACK;
							rw     <= shreg[0];
							SDA_OE <= 1'b1;
						end else if (bitc == 4'h8) begin
							i_st <= sdmc_pkg::I_IDLE;
						end
					end
					sdmc_pkg::I_AACK: begin
						bitc     <= 4'h0;
						byte_idx <= 2'h1;
						if (rw) begin
							i_st   <= sdmc_pkg::I_RDAT;
							fetch  <= 1'b1;                // [RULE10]
							SDA_OE <= ~tx_first[7];
							tx     <= {tx_first[6:0], 1'b0};
						end else begin
							i_st   <= sdmc_pkg::I_WDAT;
							mreq   <= (m_st == sdmc_pkg::M_OUT);
							SDA_OE <= 1'b0;
						end
					end
					sdmc_pkg::I_WDAT: begin
						if (bitc == 4'h8) begin
							i_st     <= sdmc_pkg::I_DACK;
							SDA_OE   <= 1'b1;
							cmd_stb  <= 1'b1;
							cmd_byte <= shreg;
						end
					end
					sdmc_pkg::I_DACK: begin
						i_st   <= sdmc_pkg::I_WDAT;
						bitc   <= 4'h0;
						SDA_OE <= 1'b0;
					end
					sdmc_pkg::I_RDAT: begin
						if (bitc == 4'h8) begin
							i_st   <= sdmc_pkg::I_RACK;
							SDA_OE <= 1'b0;
						end else begin
							SDA_OE <= ~tx[7];
							tx     <= {tx[6:0], 1'b0};
						end
					end
					sdmc_pkg::I_RACK: begin
						bitc <= 4'h0;
						if (acked) begin
							i_st     <= sdmc_pkg::I_RDAT;
							byte_idx <= byte_idx + 2'h1;
							SDA_OE   <= ~tx_byte[7];
							tx       <= {tx_byte[6:0], 1'b0};
						end else begin
							i_st <= sdmc_pkg::I_IDLE;
						end
					end
					default: i_st <= sdmc_pkg::I_IDLE;
				endcase
			end
		end
	end

	// Phase lengths; only the window length depends on the configuration
	localparam logic [sdmc_pkg::CNT_W-1:0] win_slow = WIN_SLOW_CYC[sdmc_pkg::CNT_W-1:0];
	localparam logic [sdmc_pkg::CNT_W-1:0] win_fast = WIN_FAST_CYC[sdmc_pkg::CNT_W-1:0];
	localparam logic [sdmc_pkg::CNT_W-1:0] temp_len = TEMP_CYC[sdmc_pkg::CNT_W-1:0];
	localparam logic [sdmc_pkg::CNT_W-1:0] hum_len = HUM_CYC[sdmc_pkg::CNT_W-1:0];
	localparam logic [sdmc_pkg::CNT_W-1:0] calc_len = CALC_CYC[sdmc_pkg::CNT_W-1:0];
	wire [sdmc_pkg::CNT_W-1:0] lim = (m_st == sdmc_pkg::M_WIN) ? (quick ? win_fast : win_slow) :  // [RULE2]
	                                 (m_st == sdmc_pkg::M_TEMP) ? temp_len :
	                                 (m_st == sdmc_pkg::M_HUM) ? hum_len : calc_len;
	wire tmo = (cnt >= lim - 1'b1);
	wire cm_cmd = cmd_stb & (cmd_byte == sdmc_pkg::ENTER_CM_CODE);    // [RULE11]
	wire nom_cmd = cmd_stb & (cmd_byte == sdmc_pkg::ENTER_NOM_CODE);  // [RULE11]
	wire done = (m_st == sdmc_pkg::M_CALC) & tmo;

	always_comb begin
		next_m_st = m_st;
		case (m_st)
			sdmc_pkg::M_WIN: begin
				if (cm_cmd)
					next_m_st = sdmc_pkg::M_CMD;     // [RULE3]
				else if (tmo)
					next_m_st = sdmc_pkg::M_TEMP;    // [RULE4]
			end
			sdmc_pkg::M_CMD:  if (nom_cmd) next_m_st = sdmc_pkg::M_TEMP;  // [RULE5]
			sdmc_pkg::M_TEMP: if (tmo) next_m_st = sdmc_pkg::M_HUM;       // [RULE9]
			sdmc_pkg::M_HUM:  if (tmo) next_m_st = sdmc_pkg::M_CALC;      // [RULE9]
			sdmc_pkg::M_CALC: if (tmo) next_m_st = sdmc_pkg::M_OUT;       // [RULE9]
			sdmc_pkg::M_OUT:  if (mreq) next_m_st = sdmc_pkg::M_TEMP;
			default: next_m_st = sdmc_pkg::M_WIN;
		endcase
	end

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			m_st <= sdmc_pkg::M_WIN;
			cnt  <= '0;
		end else begin
			m_st <= next_m_st;
			cnt  <= (next_m_st != m_st) ? '0 : cnt + 1'b1;
		end
	end

	// Results land in the output register only when the cycle ends
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			meas_t <= sdmc_pkg::MEAS_RST;
			meas_h <= sdmc_pkg::MEAS_RST;
			outreg <= '0;
		end else begin
			if (m_st == sdmc_pkg::M_TEMP && tmo)
				meas_t <= MEAS_IN.temp;
			if (m_st == sdmc_pkg::M_HUM && tmo)
				meas_h <= MEAS_IN.hum;
			if (done)
				outreg <= '{hum: meas_h, temp: meas_t};                  // [RULE9]
		end
	end

	// New data beats a fetch in the same cycle
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			ready <= 1'b0;
			stale <= 1'b0;
		end else begin
			ready <= done | (ready & ~fetch);                            // [RULE10]
			stale <= ~done & (stale | fetch);
		end
	end

	assign SDA_OUT = 1'b0;
	assign READY = ready;
	assign COMMAND_MODE = (m_st == sdmc_pkg::M_CMD);
	assign I2C_ACTIVE = i2c_on;
	assign MEAS_BUSY = (m_st == sdmc_pkg::M_TEMP) | (m_st == sdmc_pkg::M_HUM) | (m_st == sdmc_pkg::M_CALC);

	// Checker helpers
	logic [sdmc_pkg::BOOT_W-1:0] boot_cnt;
	logic                        seen_ready;
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			boot_cnt   <= '0;
			seen_ready <= 1'b0;
		end else begin
			boot_cnt   <= seen_ready ? boot_cnt : boot_cnt + 1'b1;
			seen_ready <= seen_ready | ready;
		end
	end

	property p_boot_slave;
		@(posedge REF_CLK) disable iff (!RST_N) in_boot |-> I2C_ACTIVE;
	endproperty
	a_boot_slave: assert property (p_boot_slave) else $error("I2C off during start-up"); // [RULE1]
	property p_win_holds;
		@(posedge REF_CLK) disable iff (!RST_N) m_st == sdmc_pkg::M_WIN && !tmo && !cm_cmd |=> m_st == sdmc_pkg::M_WIN;
	endproperty
	a_win_holds: assert property (p_win_holds) else $error("Window closed early"); // [RULE2]
	property p_cm_enter;
		@(posedge REF_CLK) disable iff (!RST_N)
			m_st == sdmc_pkg::M_WIN && cm_cmd |=> (COMMAND_MODE && !MEAS_BUSY) [*3];
	endproperty
	a_cm_enter: assert property (p_cm_enter) else $error("Command mode not entered"); // [RULE3]
	property p_win_timeout;
		@(posedge REF_CLK) disable iff (!RST_N)
			m_st == sdmc_pkg::M_WIN && tmo && !cm_cmd |=> m_st == sdmc_pkg::M_TEMP && cnt == '0;
	endproperty
	a_win_timeout: assert property (p_win_timeout) else $error("Timeout did not start cycle"); // [RULE4]
	property p_nom;
		@(posedge REF_CLK) disable iff (!RST_N) COMMAND_MODE && nom_cmd |=> MEAS_BUSY && !COMMAND_MODE;
	endproperty
	a_nom: assert property (p_nom) else $error("Normal operation not entered"); // [RULE5]
	property p_addr_miss;
		@(posedge REF_CLK) disable iff (!RST_N)
			i_st == sdmc_pkg::I_ADDR && scl_fall && bitc == 4'h8 && !addr_hit && !bus_start |=> !SDA_OE;
	endproperty
	a_addr_miss: assert property (p_addr_miss) else $error("Acked foreign address"); // [RULE6]
	property p_startup;
		@(posedge REF_CLK) disable iff (!RST_N)
			$rose(READY) && !seen_ready |-> boot_cnt <= sdmc_pkg::STA_MAX_CYC[sdmc_pkg::BOOT_W-1:0];
	endproperty
	a_startup: assert property (p_startup) else $error("First data too late"); // [RULE8]
	property p_order;
		@(posedge REF_CLK) disable iff (!RST_N)
			m_st == sdmc_pkg::M_TEMP && tmo |=> m_st == sdmc_pkg::M_HUM && !$rose(READY);
	endproperty
	a_order: assert property (p_order) else $error("Humidity did not follow temperature"); // [RULE9]
	property p_ready_hold;
		@(posedge REF_CLK) disable iff (!RST_N) READY && !fetch |=> READY;
	endproperty
	a_ready_hold: assert property (p_ready_hold) else $error("Ready dropped without fetch"); // [RULE10]
	property p_ready_set;
		@(posedge REF_CLK) disable iff (!RST_N) done |=> READY && m_st == sdmc_pkg::M_OUT;
	endproperty
	a_ready_set: assert property (p_ready_set) else $error("Ready missing after cycle"); // [RULE10]
endmodule : sdmc_top
